/* hw/sdpb_param_bank.sv */
// Diagnosis parameter bank: forced outputs, I/O status, drift words, adjustment command
//
// Functional notes
// - Forced-output word 0..0x1F; nonzero forces outputs
// - Forced outputs ignored while servo is on
// - Input status word is read-only
// - Bit 0 is input one, bit 7 input eight
// - Output status returns live outputs, 0..0x1F
// - Command codes 1..6 select calibration steps
// - Commands act only under protection mode 20
// - Drift words writable only under mode 22
// - Drift words 0..32767, factory value at reset
// - Mode 10 blocks factory restore of drift words
// - Code 2 recalibrates the torque drift words
`default_nettype none
module sdpb_param_bank (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               reset_i,
  // Parameter access port
  input  wire logic               param_wr_i,
  input  wire logic               param_rd_i,
  input  wire logic [15:0]        param_addr_i,
  input  wire logic [15:0]        param_wdata_i,
  output logic [15:0]             param_rdata_o,
  output logic                    param_ack_o,
  output logic                    param_err_o,
  // Drive state
  input  wire logic [7:0]         protection_mode_param_i,
  input  wire logic               servo_on_i,
  input  wire logic               restore_defaults_i,
  // Digital I/O
  input  wire logic [7:0]         digital_input_i,
  input  wire logic [4:0]         normal_output_i,
  input  wire logic [15:0]        keypad_input_i,
  output logic [4:0]              digital_output_o,
  // Analog zero samples and calibration status
  input  wire logic [14:0]        speed_sample_i,
  input  wire logic [14:0]        torque_sample_i,
  output logic [5:0]              cal_step_o,
  output logic [14:0]             speed_drift_first_o,
  output logic [14:0]             speed_drift_second_o,
  output logic [14:0]             torque_drift_first_o,
  output logic [14:0]             torque_drift_second_o
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  function automatic logic drift_hit(input logic [15:0] a);
    return a >= sdpb_pkg::ADDR_SPD_FIRST && a <= sdpb_pkg::ADDR_TRQ_SECOND;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser for the digital inputs
  logic [7:0] di_meta_reg;
  logic [7:0] di_sync_reg;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      di_meta_reg <= 8'h00;
      di_sync_reg <= 8'h00;
    end else begin
      di_meta_reg <= digital_input_i;
      di_sync_reg <= di_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sdpb_pkg::sdpb_cal_state_t cal_state;
  logic        cal_done;
  logic        cal_spd_wr;
  logic        cal_trq_wr;
  logic [14:0] cal_first;
  logic [14:0] cal_second;
  logic        cal_start;

  logic [15:0] forced_reg, forced_next;
  logic [15:0] adj_reg, adj_next;
  logic [14:0] spd1_reg, spd1_next, spd2_reg, spd2_next;
  logic [14:0] trq1_reg, trq1_next, trq2_reg, trq2_next;
  logic [15:0] keypad_reg;
  logic [4:0]  dout_reg, dout_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        ack_reg, ack_next, err_reg, err_next;
  logic        start_reg, start_next;
  logic        cal_busy;
  logic        wr_ok;

  // Done cycle counts as busy: results land then and must not be overridden
  assign cal_busy  = (cal_state != sdpb_pkg::CAL_IDLE) || start_reg || cal_done;
  assign cal_start = start_reg;

  sdpb_cal_engine i_sdpb_cal_engine (
    .sys_clk_i       (sys_clk_i),
    .reset_i         (reset_i),
    .start_i         (cal_start),
    .code_i          (adj_reg),
    .speed_sample_i  (speed_sample_i),
    .torque_sample_i (torque_sample_i),
    .state_o         (cal_state),
    .done_o          (cal_done),
    .speed_wr_o      (cal_spd_wr),
    .torque_wr_o     (cal_trq_wr),
    .first_o         (cal_first),
    .second_o        (cal_second)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    forced_next = forced_reg;
    adj_next    = adj_reg;
    spd1_next   = spd1_reg;
    spd2_next   = spd2_reg;
    trq1_next   = trq1_reg;
    trq2_next   = trq2_reg;
    start_next  = 1'b0;
    rdata_next  = 16'h0000;
    ack_next    = param_wr_i || param_rd_i;
    err_next    = 1'b0;
    wr_ok       = 1'b0;
    // Forced pattern only while enabled and the servo is off
    dout_next   = (forced_reg != 16'h0000 && !servo_on_i) ? forced_reg[4:0]
                                                          : normal_output_i;
    if (param_wr_i) begin
      if (hit(param_addr_i, sdpb_pkg::ADDR_FORCED_OUT)) begin
        wr_ok = param_wdata_i <= sdpb_pkg::FORCED_MAX;
        if (wr_ok) begin
          forced_next = param_wdata_i;
        end
      end else if (hit(param_addr_i, sdpb_pkg::ADDR_ADJ_CMD)) begin
        // A command is taken only when idle and unlocked for automatic adjust
        wr_ok = protection_mode_param_i == sdpb_pkg::PROT_AUTO_ADJ
                && param_wdata_i <= sdpb_pkg::ADJ_THERM && !cal_busy;
        if (wr_ok) begin
          adj_next   = param_wdata_i;
          start_next = param_wdata_i != sdpb_pkg::ADJ_NONE;
        end
      end else if (drift_hit(param_addr_i)) begin
        wr_ok = protection_mode_param_i == sdpb_pkg::PROT_MANUAL
                && param_wdata_i <= sdpb_pkg::DRIFT_MAX && !cal_busy;
        if (wr_ok && hit(param_addr_i, sdpb_pkg::ADDR_SPD_FIRST)) begin
          spd1_next = param_wdata_i[14:0];
        end
        if (wr_ok && hit(param_addr_i, sdpb_pkg::ADDR_SPD_SECOND)) begin
          spd2_next = param_wdata_i[14:0];
        end
        if (wr_ok && hit(param_addr_i, sdpb_pkg::ADDR_TRQ_FIRST)) begin
          trq1_next = param_wdata_i[14:0];
        end
        if (wr_ok && hit(param_addr_i, sdpb_pkg::ADDR_TRQ_SECOND)) begin
          trq2_next = param_wdata_i[14:0];
        end
      end
      // Status words and unmapped addresses refuse writes
      err_next = !wr_ok;
    end else if (param_rd_i) begin
      unique case (param_addr_i)
        sdpb_pkg::ADDR_FORCED_OUT:  rdata_next = forced_reg;
        sdpb_pkg::ADDR_INPUT_STAT:  rdata_next = {8'h00, di_sync_reg};
        sdpb_pkg::ADDR_KEYPAD:      rdata_next = keypad_reg;
        sdpb_pkg::ADDR_OUTPUT_STAT: rdata_next = {11'h000, dout_reg};
        sdpb_pkg::ADDR_ADJ_CMD:     rdata_next = adj_reg;
        sdpb_pkg::ADDR_SPD_FIRST:   rdata_next = {1'b0, spd1_reg};
        sdpb_pkg::ADDR_SPD_SECOND:  rdata_next = {1'b0, spd2_reg};
        sdpb_pkg::ADDR_TRQ_FIRST:   rdata_next = {1'b0, trq1_reg};
        sdpb_pkg::ADDR_TRQ_SECOND:  rdata_next = {1'b0, trq2_reg};
        default:                    err_next   = 1'b1;
      endcase
    end
    // Calibration results outrank any concurrent access
    if (cal_spd_wr) begin
      spd1_next = cal_first;
      spd2_next = cal_second;
    end
    if (cal_trq_wr) begin
      trq1_next = cal_first;
      trq2_next = cal_second;
    end
    if (cal_done) begin
      adj_next = sdpb_pkg::ADJ_NONE;
    end
    // Factory restore, unless the words are locked or a calibration is busy
    if (restore_defaults_i && protection_mode_param_i != sdpb_pkg::PROT_LOCK && !cal_busy) begin
      spd1_next = sdpb_pkg::DRIFT_FACTORY;
      spd2_next = sdpb_pkg::DRIFT_FACTORY;
      trq1_next = sdpb_pkg::DRIFT_FACTORY;
      trq2_next = sdpb_pkg::DRIFT_FACTORY;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      forced_reg <= sdpb_pkg::FORCED_RESET;
      adj_reg    <= sdpb_pkg::ADJ_RESET;
      spd1_reg   <= sdpb_pkg::DRIFT_FACTORY;
      spd2_reg   <= sdpb_pkg::DRIFT_FACTORY;
      trq1_reg   <= sdpb_pkg::DRIFT_FACTORY;
      trq2_reg   <= sdpb_pkg::DRIFT_FACTORY;
      keypad_reg <= 16'h0000;
      dout_reg   <= 5'h00;
      rdata_reg  <= 16'h0000;
      ack_reg    <= 1'b0;
      err_reg    <= 1'b0;
      start_reg  <= 1'b0;
    end else begin
      forced_reg <= forced_next;
      adj_reg    <= adj_next;
      spd1_reg   <= spd1_next;
      spd2_reg   <= spd2_next;
      trq1_reg   <= trq1_next;
      trq2_reg   <= trq2_next;
      keypad_reg <= keypad_input_i;
      dout_reg   <= dout_next;
      rdata_reg  <= rdata_next;
      ack_reg    <= ack_next;
      err_reg    <= err_next;
      start_reg  <= start_next;
    end
  end

  assign param_rdata_o         = rdata_reg;
  assign param_ack_o           = ack_reg;
  assign param_err_o           = err_reg;
  assign digital_output_o      = dout_reg;
  assign cal_step_o            = cal_state;
  assign speed_drift_first_o   = spd1_reg;
  assign speed_drift_second_o  = spd2_reg;
  assign torque_drift_first_o  = trq1_reg;
  assign torque_drift_second_o = trq2_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  AST_FORCED_DRIVES: assert property (
    forced_reg != 16'h0000 && !servo_on_i |=> dout_reg == $past(forced_reg[4:0]))
    else $error("forced pattern not driven");
  AST_FORCED_RANGE: assert property (forced_reg <= sdpb_pkg::FORCED_MAX)
    else $error("forced word out of range");
  AST_SERVO_ON_NORMAL: assert property (
    servo_on_i |=> dout_reg == $past(normal_output_i))
    else $error("forced output acted while servo on");
  AST_INPUT_RO: assert property (
    param_wr_i && param_addr_i == sdpb_pkg::ADDR_INPUT_STAT |=> param_err_o)
    else $error("input status write not refused");
  AST_INPUT_MAP: assert property (
    param_rd_i && !param_wr_i && param_addr_i == sdpb_pkg::ADDR_INPUT_STAT
    |-> ##1 param_rdata_o == {8'h00, $past(di_sync_reg)})
    else $error("input status bit map wrong");
  AST_OUTPUT_STATUS: assert property (
    param_rd_i && !param_wr_i && param_addr_i == sdpb_pkg::ADDR_OUTPUT_STAT
    |=> param_rdata_o == {11'h000, $past(dout_reg)})
    else $error("output status not live");
  AST_CMD_STARTS: assert property (
    param_wr_i && param_addr_i == sdpb_pkg::ADDR_ADJ_CMD && param_wdata_i == sdpb_pkg::ADJ_TORQUE
    && protection_mode_param_i == sdpb_pkg::PROT_AUTO_ADJ && !cal_busy
    |-> ##2 cal_state == sdpb_pkg::CAL_TORQUE)
    else $error("torque command did not start");
  AST_CMD_LOCKED: assert property (
    param_wr_i && param_addr_i == sdpb_pkg::ADDR_ADJ_CMD
    && protection_mode_param_i != sdpb_pkg::PROT_AUTO_ADJ |=> !start_reg && param_err_o)
    else $error("command taken without unlock");
  AST_DRIFT_LOCKED: assert property (
    param_wr_i && drift_hit(param_addr_i) && protection_mode_param_i != sdpb_pkg::PROT_MANUAL
    && !cal_spd_wr && !cal_trq_wr && !restore_defaults_i
    |=> $stable(spd1_reg) && $stable(trq2_reg))
    else $error("drift word written without unlock");
  AST_DRIFT_RANGE: assert property (
    param_wr_i && drift_hit(param_addr_i) && param_wdata_i > sdpb_pkg::DRIFT_MAX |=> param_err_o)
    else $error("drift value above range accepted");
  AST_LOCK_KEEPS: assert property (
    restore_defaults_i && protection_mode_param_i == sdpb_pkg::PROT_LOCK && !param_wr_i
    && !cal_spd_wr && !cal_trq_wr |=> $stable(spd1_reg) && $stable(trq1_reg))
    else $error("locked drift words were reset");
  AST_BAD_CODE: assert property (
    param_wr_i && param_addr_i == sdpb_pkg::ADDR_ADJ_CMD && param_wdata_i > sdpb_pkg::ADJ_THERM
    |=> !start_reg)
    else $error("bad command code started calibration");
  AST_DONE_CLEARS: assert property (cal_done |=> adj_reg == sdpb_pkg::ADJ_NONE)
    else $error("command word not cleared at done");

  COV_SPEED_CAL: cover property (cal_spd_wr);
  COV_TORQUE_CAL: cover property (cal_trq_wr);
  COV_FORCED: cover property (forced_reg != 16'h0000 && !servo_on_i);
  COV_ALL_TO_CUR_W: cover property (cal_state == sdpb_pkg::CAL_CUR_W);
endmodule
`default_nettype wire

/* hw/sdpb_pkg.sv */
// Constants and types shared by the diagnosis parameter bank
`default_nettype none
package sdpb_pkg;
  // Word addresses of the bank
  localparam logic [15:0] ADDR_FORCED_OUT  = 16'h0406;
  localparam logic [15:0] ADDR_INPUT_STAT  = 16'h0407;
  localparam logic [15:0] ADDR_KEYPAD      = 16'h0408;
  localparam logic [15:0] ADDR_OUTPUT_STAT = 16'h0409;
  localparam logic [15:0] ADDR_ADJ_CMD     = 16'h040A;
  localparam logic [15:0] ADDR_SPD_FIRST   = 16'h040B;
  localparam logic [15:0] ADDR_SPD_SECOND  = 16'h040C;
  localparam logic [15:0] ADDR_TRQ_FIRST   = 16'h040D;
  localparam logic [15:0] ADDR_TRQ_SECOND  = 16'h040E;
  // Ranges and reset values
  localparam logic [15:0] FORCED_MAX       = 16'h001F;
  localparam logic [15:0] DRIFT_MAX        = 16'h7FFF;
  localparam logic [15:0] FORCED_RESET     = 16'h0000;
  localparam logic [15:0] ADJ_RESET        = 16'h0000;
  localparam logic [14:0] DRIFT_FACTORY    = 15'h4000;
  localparam int          DO_W             = 5;
  localparam int          DI_W             = 8;
  // Adjustment command codes
  localparam logic [15:0] ADJ_NONE         = 16'h0000;
  localparam logic [15:0] ADJ_SPEED        = 16'h0001;
  localparam logic [15:0] ADJ_TORQUE       = 16'h0002;
  localparam logic [15:0] ADJ_CUR_V        = 16'h0003;
  localparam logic [15:0] ADJ_CUR_W        = 16'h0004;
  localparam logic [15:0] ADJ_ALL          = 16'h0005;
  localparam logic [15:0] ADJ_THERM        = 16'h0006;
  // Protection mode values
  localparam logic [7:0]  PROT_LOCK        = 8'h0A;
  localparam logic [7:0]  PROT_AUTO_ADJ    = 8'h14;
  localparam logic [7:0]  PROT_MANUAL      = 8'h16;
  // Calibration step timing
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          CAL_STEP_NS      = 10000;
  localparam int          CAL_STEP_CYC     = CAL_STEP_NS / CLK_PERIOD_NS;
  localparam logic [11:0] CAL_LAST         = 12'(CAL_STEP_CYC - 1);
  localparam logic [11:0] CAL_HALF         = 12'(CAL_STEP_CYC / 2);

  typedef enum logic [5:0] {
    CAL_IDLE   = 6'b000001,
    CAL_SPEED  = 6'b000010,
    CAL_TORQUE = 6'b000100,
    CAL_CUR_V  = 6'b001000,
    CAL_CUR_W  = 6'b010000,
    CAL_THERM  = 6'b100000
  } sdpb_cal_state_t;
endpackage
`default_nettype wire

/* hw/sdpb_cal_engine.sv */
// Calibration sequencer: runs the commanded drift steps one after another
`default_nettype none
module sdpb_cal_engine (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_i,
  // Command
  input  wire logic                    start_i,
  input  wire logic [15:0]             code_i,
  // Zero-level samples of the analog inputs
  input  wire logic [14:0]             speed_sample_i,
  input  wire logic [14:0]             torque_sample_i,
  // Results
  output sdpb_pkg::sdpb_cal_state_t    state_o,
  output logic                         done_o,
  output logic                         speed_wr_o,
  output logic                         torque_wr_o,
  output logic [14:0]                  first_o,
  output logic [14:0]                  second_o
);
  sdpb_pkg::sdpb_cal_state_t state_reg, state_next;
  logic [11:0] cnt_reg, cnt_next;
  logic        all_reg, all_next;
  logic        done_reg, done_next;
  logic        spd_wr_reg, spd_wr_next;
  logic        trq_wr_reg, trq_wr_next;
  logic [14:0] first_reg, first_next;
  logic [14:0] second_reg, second_next;
  logic [14:0] sample;

  always_comb begin
    sample      = (state_reg == sdpb_pkg::CAL_TORQUE) ? torque_sample_i : speed_sample_i;
    state_next  = state_reg;
    cnt_next    = cnt_reg + 12'h001;
    all_next    = all_reg;
    done_next   = 1'b0;
    spd_wr_next = 1'b0;
    trq_wr_next = 1'b0;
    first_next  = first_reg;
    second_next = second_reg;
    unique case (state_reg)
      sdpb_pkg::CAL_IDLE: begin
        cnt_next = 12'h000;
        if (start_i) begin
          all_next = (code_i == sdpb_pkg::ADJ_ALL);
          unique case (code_i)
            sdpb_pkg::ADJ_SPEED, sdpb_pkg::ADJ_ALL: state_next = sdpb_pkg::CAL_SPEED;
            sdpb_pkg::ADJ_TORQUE: state_next = sdpb_pkg::CAL_TORQUE;
            sdpb_pkg::ADJ_CUR_V:  state_next = sdpb_pkg::CAL_CUR_V;
            sdpb_pkg::ADJ_CUR_W:  state_next = sdpb_pkg::CAL_CUR_W;
            sdpb_pkg::ADJ_THERM:  state_next = sdpb_pkg::CAL_THERM;
            default:              state_next = sdpb_pkg::CAL_IDLE;
          endcase
        end
      end
      default: begin
        // Two samples half a step apart give the two drift words
        if (cnt_reg == sdpb_pkg::CAL_HALF) begin
          first_next = sample;
        end
        if (cnt_reg == sdpb_pkg::CAL_LAST) begin
          cnt_next    = 12'h000;
          second_next = sample;
          spd_wr_next = (state_reg == sdpb_pkg::CAL_SPEED);
          trq_wr_next = (state_reg == sdpb_pkg::CAL_TORQUE);
          if (all_reg && state_reg == sdpb_pkg::CAL_SPEED) begin
            state_next = sdpb_pkg::CAL_TORQUE;
          end else if (all_reg && state_reg == sdpb_pkg::CAL_TORQUE) begin
            state_next = sdpb_pkg::CAL_CUR_V;
          end else if (all_reg && state_reg == sdpb_pkg::CAL_CUR_V) begin
            state_next = sdpb_pkg::CAL_CUR_W;
          end else begin
            state_next = sdpb_pkg::CAL_IDLE;
            done_next  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg  <= sdpb_pkg::CAL_IDLE;
      cnt_reg    <= 12'h000;
      all_reg    <= 1'b0;
      done_reg   <= 1'b0;
      spd_wr_reg <= 1'b0;
      trq_wr_reg <= 1'b0;
      first_reg  <= 15'h0000;
      second_reg <= 15'h0000;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      all_reg    <= all_next;
      done_reg   <= done_next;
      spd_wr_reg <= spd_wr_next;
      trq_wr_reg <= trq_wr_next;
      first_reg  <= first_next;
      second_reg <= second_next;
    end
  end

  assign state_o     = state_reg;
  assign done_o      = done_reg;
  assign speed_wr_o  = spd_wr_reg;
  assign torque_wr_o = trq_wr_reg;
  assign first_o     = first_reg;
  assign second_o    = second_reg;
endmodule
`default_nettype wire

/* tb/sdpb_host_model.sv */
// Host controller model that issues parameter accesses and sets drive state
`default_nettype none
module sdpb_host_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Access answer
  input  wire logic        param_ack_i,
  input  wire logic        param_err_i,
  input  wire logic [15:0] param_rdata_i,
  // Access request
  output logic             param_wr_o,
  output logic             param_rd_o,
  output logic [15:0]      param_addr_o,
  output logic [15:0]      param_wdata_o,
  // Drive state and analog zero samples held by the controller
  output logic [7:0]       protection_mode_o,
  output logic             servo_on_o,
  output logic [14:0]      speed_sample_o,
  output logic [14:0]      torque_sample_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    param_wr_o        = 1'b0;
    param_rd_o        = 1'b0;
    param_addr_o      = 16'h0000;
    param_wdata_o     = 16'h0000;
    protection_mode_o = 8'h00;
    servo_on_o        = 1'b0;
    speed_sample_o    = 15'h0000;
    torque_sample_o   = 15'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Servo stays off whenever a command may be issued
  task automatic set_state(input logic [7:0] mode, input logic servo);
    @(posedge sys_clk_i);
    #1;
    protection_mode_o = mode;
    servo_on_o        = servo;
  endtask

  // Zero-level inputs held steady for the whole calibration
  task automatic set_samples(input logic [14:0] spd, input logic [14:0] trq);
    speed_sample_o  = spd;
    torque_sample_o = trq;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Released lines show inverted values so stale data is never read as valid
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    #1;
    param_wr_o    = w;
    param_rd_o    = !w;
    param_addr_o  = a;
    param_wdata_o = d;
    @(posedge sys_clk_i);
    #1;
    param_wr_o    = 1'b0;
    param_rd_o    = 1'b0;
    param_addr_o  = ~a;
    param_wdata_o = ~d;
    while (param_ack_i !== 1'b1 && n < 2) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    rdata = (param_ack_i === 1'b1) ? param_rdata_i : 16'hXXXX;
    err   = (param_ack_i === 1'b1) ? param_err_i : 1'bx;
  endtask
endmodule
`default_nettype wire

/* tb/sdpb_param_bank_tb.sv */
// Self-checking testbench of the diagnosis parameter bank
`default_nettype none
module sdpb_param_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr, rd, ack, err, servo, rstd = 1'b0;
  logic [15:0] addr, wdata, rdata;
  logic [15:0] keypad = 16'hA5C3;
  logic [7:0]  mode;
  logic [7:0]  din = 8'h00;
  logic [4:0]  nout = 5'h0A;
  logic [4:0]  dout;
  logic [5:0]  step;
  logic [14:0] spd_s, trq_s, sf, ss, tf, ts;
  int          errors = 0;
  int          comparisons = 0;

  always #5 clk = ~clk;

  sdpb_host_model i_sdpb_host_model (.sys_clk_i(clk), .param_ack_i(ack), .param_err_i(err),
    .param_rdata_i(rdata), .param_wr_o(wr), .param_rd_o(rd), .param_addr_o(addr),
    .param_wdata_o(wdata), .protection_mode_o(mode), .servo_on_o(servo),
    .speed_sample_o(spd_s), .torque_sample_o(trq_s));

  sdpb_param_bank i_sdpb_param_bank (.sys_clk_i(clk), .reset_i(rst), .param_wr_i(wr),
    .param_rd_i(rd), .param_addr_i(addr), .param_wdata_i(wdata), .param_rdata_o(rdata),
    .param_ack_o(ack), .param_err_o(err), .protection_mode_param_i(mode),
    .servo_on_i(servo), .restore_defaults_i(rstd), .digital_input_i(din),
    .normal_output_i(nout), .keypad_input_i(keypad), .digital_output_o(dout),
    .speed_sample_i(spd_s), .torque_sample_i(trq_s), .cal_step_o(step),
    .speed_drift_first_o(sf), .speed_drift_second_o(ss), .torque_drift_first_o(tf),
    .torque_drift_second_o(ts));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read data is judged only on accepted reads
  task automatic op(input logic w, input logic [15:0] a, input logic [15:0] d,
                    input logic [15:0] exp, input logic e);
    logic [15:0] r;
    logic        er;
    i_sdpb_host_model.access(w, a, d, r, er);
    chk({15'h0000, er}, {15'h0000, e});
    if (!w && !e) chk(r, exp);
  endtask

  task automatic restore_pulse();
    @(posedge clk);
    #1 rstd = 1'b1;
    @(posedge clk);
    #1 rstd = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    op(1'b0, sdpb_pkg::ADDR_FORCED_OUT, 16'h0000, 16'h0000, 1'b0);
    op(1'b0, sdpb_pkg::ADDR_ADJ_CMD, 16'h0000, 16'h0000, 1'b0);
    for (int a = 16'h040B; a <= 16'h040E; a++) begin
      op(1'b0, 16'(a), 16'h0000, 16'h4000, 1'b0);
    end
    op(1'b0, 16'h0405, 16'h0000, 16'h0000, 1'b1);
    op(1'b0, sdpb_pkg::ADDR_KEYPAD, 16'h0000, 16'hA5C3, 1'b0);
  endtask

  task automatic t_forced();
    op(1'b1, sdpb_pkg::ADDR_FORCED_OUT, 16'h001F, 16'h0000, 1'b0);
    repeat (2) @(posedge clk);
    chk({11'h000, dout}, 16'h001F);
    op(1'b0, sdpb_pkg::ADDR_OUTPUT_STAT, 16'h0000, 16'h001F, 1'b0);
    op(1'b1, sdpb_pkg::ADDR_FORCED_OUT, 16'h0020, 16'h0000, 1'b1);
    op(1'b0, sdpb_pkg::ADDR_FORCED_OUT, 16'h0000, 16'h001F, 1'b0);
    i_sdpb_host_model.set_state(8'h00, 1'b1);
    repeat (2) @(posedge clk);
    chk({11'h000, dout}, 16'h000A);
    i_sdpb_host_model.set_state(8'h00, 1'b0);
    op(1'b1, sdpb_pkg::ADDR_FORCED_OUT, 16'h0000, 16'h0000, 1'b0);
    repeat (2) @(posedge clk);
    chk({11'h000, dout}, 16'h000A);
  endtask

  task automatic t_status();
    #1 din = 8'h81;
    repeat (4) @(posedge clk);
    op(1'b0, sdpb_pkg::ADDR_INPUT_STAT, 16'h0000, 16'h0081, 1'b0);
    op(1'b1, sdpb_pkg::ADDR_INPUT_STAT, 16'h00FF, 16'h0000, 1'b1);
    op(1'b1, sdpb_pkg::ADDR_OUTPUT_STAT, 16'h0001, 16'h0000, 1'b1);
  endtask

  task automatic t_drift();
    i_sdpb_host_model.set_state(8'h14, 1'b0);
    op(1'b1, sdpb_pkg::ADDR_SPD_FIRST, 16'h1234, 16'h0000, 1'b1);
    i_sdpb_host_model.set_state(8'h16, 1'b0);
    op(1'b1, sdpb_pkg::ADDR_SPD_FIRST, 16'h7FFF, 16'h0000, 1'b0);
    op(1'b1, sdpb_pkg::ADDR_TRQ_SECOND, 16'h8000, 16'h0000, 1'b1);
    op(1'b1, sdpb_pkg::ADDR_ADJ_CMD, 16'h0001, 16'h0000, 1'b1);
    i_sdpb_host_model.set_state(8'h0A, 1'b0);
    restore_pulse();
    op(1'b0, sdpb_pkg::ADDR_SPD_FIRST, 16'h0000, 16'h7FFF, 1'b0);
    i_sdpb_host_model.set_state(8'h16, 1'b0);
    restore_pulse();
    op(1'b0, sdpb_pkg::ADDR_SPD_FIRST, 16'h0000, 16'h4000, 1'b0);
  endtask

  // First engine step seen for codes 1 to 6
  task automatic t_cal();
    logic [5:0]  first_step [1:6] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h02, 6'h20};
    logic [15:0] r;
    logic        er;
    int          n;
    i_sdpb_host_model.set_samples(15'h0123, 15'h0456);
    i_sdpb_host_model.set_state(8'h14, 1'b0);
    op(1'b1, sdpb_pkg::ADDR_ADJ_CMD, 16'h0007, 16'h0000, 1'b1);
    op(1'b1, sdpb_pkg::ADDR_ADJ_CMD, 16'h0000, 16'h0000, 1'b0);
    @(posedge clk);
    #1 chk({10'h000, step}, 16'h0001);
    for (int c = 1; c <= 6; c++) begin
      op(1'b1, sdpb_pkg::ADDR_ADJ_CMD, 16'(c), 16'h0000, 1'b0);
      @(posedge clk);
      #1 chk({10'h000, step}, {10'h000, first_step[c]});
      n = 0;
      r = 16'hFFFF;
      while (r !== 16'h0000 && n < 3000) begin
        i_sdpb_host_model.access(1'b0, sdpb_pkg::ADDR_ADJ_CMD, 16'h0000, r, er);
        n++;
      end
      chk(r, 16'h0000);
      if (c == 1) begin
        chk({1'b0, sf}, 16'h0123);
        chk({1'b0, ss}, 16'h0123);
        chk({1'b0, tf}, 16'h4000);
      end
      if (c == 2) begin
        chk({1'b0, tf}, 16'h0456);
        chk({1'b0, ts}, 16'h0456);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_forced();
    t_status();
    t_drift();
    t_cal();
    report_and_stop();
  end

  // Whole run needs about 9100 cycles
  initial begin
    #300000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
